// *** rtl/anps_pkg.sv ***
package anps_pkg;

  // management register addresses (5-bit register field of a management frame)
  localparam logic [4:0] REG_LINK_PARTNER_ABILITY = 5'h05;
  localparam logic [4:0] REG_AUTONEG_EXPANSION    = 5'h06;

  // partner ability, base-page layout
  localparam int LPA_MORE_PAGES     = 15;
  localparam int LPA_ACKNOWLEDGE    = 14;
  localparam int LPA_FAULT_FLAG     = 13;
  localparam int LPA_RSVD_HI        = 12;
  localparam int LPA_RSVD_LO        = 10;
  localparam int LPA_T4_CAPABLE     = 9;
  localparam int LPA_FAST_FDX       = 8;
  localparam int LPA_FAST_CAPABLE   = 7;
  localparam int LPA_SLOW_FDX       = 6;
  localparam int LPA_SLOW_CAPABLE   = 5;
  localparam int LPA_SELECTOR_HI    = 4;
  localparam int LPA_SELECTOR_LO    = 0;

  // partner ability, next-page layout
  localparam int LPN_MESSAGE_FLAG   = 13;
  localparam int LPN_COMPLY_FLAG    = 12;
  localparam int LPN_ALTERNATE_BIT  = 11;
  localparam int LPN_CODE_HI        = 10;
  localparam int LPN_CODE_LO        = 0;

  // expansion layout
  localparam int EXP_PARALLEL_ERROR = 4;
  localparam int EXP_PARTNER_EXTRA  = 3;
  localparam int EXP_OWN_EXTRA      = 2;
  localparam int EXP_PAGE_ARRIVED   = 1;
  localparam int EXP_PARTNER_NEG    = 0;

  localparam logic [15:0] RESET_WORD       = 16'h0000;
  localparam logic [15:0] RSVD_BASE_MASK   = 16'h1c00;
  localparam logic [4:0]  STD_SELECTOR     = 5'h01;
  localparam int          NUM_TECHNOLOGIES = 3;

  typedef enum logic [1:0] {
    PG_BASE = 2'b00,
    PG_NEXT = 2'b01
  } anps_page_t;

endpackage : anps_pkg

// *** rtl/anps_page_store.sv ***
// holds the last received link code word; read data registered
module anps_page_store (
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic        wrEn,
  input  wire logic [15:0] wrWord,
  output logic [15:0]      rdWord
);

  logic [15:0] word_q;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      word_q <= anps_pkg::RESET_WORD;
    end else if (wrEn) begin
      word_q <= wrWord;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      rdWord <= anps_pkg::RESET_WORD;
    end else begin
      rdWord <= word_q;
    end
  end

endmodule : anps_page_store

// *** rtl/anps_fault_detect.sv ***
// flags more than one technology seeing a valid link in the same cycle
module anps_fault_detect (
  input  wire logic                                 mclk,
  input  wire logic                                 nrst,
  input  wire logic [anps_pkg::NUM_TECHNOLOGIES-1:0] linkValid,
  output logic                                      multiLink
);

  function automatic logic more_than_one(
    input logic [anps_pkg::NUM_TECHNOLOGIES-1:0] v
  );
    logic seen;
    logic two;
    seen = 1'b0;
    two  = 1'b0;
    for (int i = 0; i < anps_pkg::NUM_TECHNOLOGIES; i++) begin
      two  = two | (seen & v[i]);
      seen = seen | v[i];
    end
    return two;
  endfunction : more_than_one

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      multiLink <= 1'b0;
    end else begin
      multiLink <= more_than_one(linkValid); // R14
    end
  end

endmodule : anps_fault_detect

// *** rtl/anps_status_regs.sv ***
// How it works
// R1: base page bit 15 shows partner next-page request
// R2: base page bit 14 shows partner acknowledge
// R3: base page bit 13 shows partner fault
// R4: bits 9..5 show partner technology abilities
// R5: base bits 12..10 reserved, read-only
// R6: bits 4..0 show partner selector field
// R7: next page bit 15 shows more pages
// R8: next page bit 14 shows partner acknowledge
// R9: next page bit 13 shows message page
// R10: next page bit 12 shows comply flag
// R11: next page bit 11 shows alternating bit
// R12: next page bits 10..0 show code field
// R13: parallel fault latches, cleared by expansion read
// R14: fault when several technologies see link
// R15: expansion bit 3 shows partner next-page support
// R16: expansion bit 2 always reads one
// R17: expansion bit 1 latches on page arrival
// R18: expansion bit 0 shows partner negotiation ability
// R19: latched flags clear only on read or reset
// R20: switch to next-page layout once exchange begins
// R21: writes ignored, reads always defined
module anps_status_regs (
  input  wire logic                                 mclk,
  input  wire logic                                 nrst,
  // from the arbitration function, same clock
  input  wire logic                                 pageValid,
  input  wire logic [15:0]                          pageWord,
  input  wire logic                                 nextPageActive,
  input  wire logic                                 partnerNegotiates,
  input  wire logic [anps_pkg::NUM_TECHNOLOGIES-1:0] linkValid,
  // management access, same clock
  input  wire logic                                 mgmtRead,
  input  wire logic                                 mgmtWrite,
  input  wire logic [4:0]                           mgmtAddr,
  input  wire logic [15:0]                          mgmtWrData,
  output logic [15:0]                               mgmtRdData,
  output logic                                      mgmtRdValid,
  output logic                                      parallelErrorOut
);

  logic [15:0]        pageStored;
  logic               multiLink;
  logic               parallelError_q;
  logic               pageArrived_q;
  logic               partnerExtra_q;
  logic               partnerNeg_q;
  anps_pkg::anps_page_t pageFmt_q;
  logic [15:0]        ability;
  logic [15:0]        expansion;
  logic               readExp;
  logic               unusedWrite;

  // writes carry no effect on these read-only registers
  assign unusedWrite = mgmtWrite ^ (^mgmtWrData); // R21

  anps_page_store u_store (
    .mclk   (mclk),
    .nrst   (nrst),
    .wrEn   (pageValid),
    .wrWord (pageWord),
    .rdWord (pageStored)
  );

  anps_fault_detect u_fault (
    .mclk      (mclk),
    .nrst      (nrst),
    .linkValid (linkValid),
    .multiLink (multiLink)
  );

  assign readExp = mgmtRead && (mgmtAddr == anps_pkg::REG_AUTONEG_EXPANSION);

  // layout follows the exchange phase
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      pageFmt_q <= anps_pkg::PG_BASE;
    end else begin
      case (pageFmt_q)
        anps_pkg::PG_BASE: begin
          if (nextPageActive) begin
            pageFmt_q <= anps_pkg::PG_NEXT; // R20
          end
        end
        anps_pkg::PG_NEXT: begin
          if (!nextPageActive) begin
            pageFmt_q <= anps_pkg::PG_BASE;
          end
        end
        default: pageFmt_q <= anps_pkg::PG_BASE;
      endcase
    end
  end

  // set wins over the read clear so no event is lost
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      parallelError_q <= 1'b0;
    end else if (multiLink) begin
      parallelError_q <= 1'b1; // R13
    end else if (readExp) begin
      parallelError_q <= 1'b0; // R19
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      pageArrived_q <= 1'b0;
    end else if (pageValid) begin
      pageArrived_q <= 1'b1; // R17
    end else if (readExp) begin
      pageArrived_q <= 1'b0; // R19
    end
  end

  // partner next-page support taken from the base page only
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      partnerExtra_q <= 1'b0;
      partnerNeg_q   <= 1'b0;
    end else begin
      partnerNeg_q <= partnerNegotiates; // R18
      if (pageValid && pageFmt_q == anps_pkg::PG_BASE) begin
        partnerExtra_q <= pageWord[anps_pkg::LPA_MORE_PAGES]; // R15
      end
    end
  end

  // both layouts share bits 15..14 positions; base masks reserved bits
  always_comb begin
    ability = pageStored; // R1 R2 R3 R4 R6 R7 R8 R9 R10 R11 R12
    if (pageFmt_q == anps_pkg::PG_BASE) begin
      ability = pageStored & ~anps_pkg::RSVD_BASE_MASK; // R5
    end
  end

  always_comb begin
    expansion = anps_pkg::RESET_WORD;
    expansion[anps_pkg::EXP_PARALLEL_ERROR] = parallelError_q;
    expansion[anps_pkg::EXP_PARTNER_EXTRA]  = partnerExtra_q;
    expansion[anps_pkg::EXP_OWN_EXTRA]      = 1'b1; // R16
    expansion[anps_pkg::EXP_PAGE_ARRIVED]   = pageArrived_q;
    expansion[anps_pkg::EXP_PARTNER_NEG]    = partnerNeg_q;
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      mgmtRdData  <= anps_pkg::RESET_WORD;
      mgmtRdValid <= 1'b0;
    end else begin
      mgmtRdValid <= mgmtRead;
      if (mgmtRead) begin
        case (mgmtAddr)
          anps_pkg::REG_LINK_PARTNER_ABILITY: mgmtRdData <= ability;
          anps_pkg::REG_AUTONEG_EXPANSION:    mgmtRdData <= expansion;
          default:                            mgmtRdData <= anps_pkg::RESET_WORD; // R21
        endcase
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      parallelErrorOut <= 1'b0;
    end else begin
      parallelErrorOut <= parallelError_q;
    end
  end

  // checker side: own copy of the last page, kept apart from the page store
  logic [15:0] shadowPage_q;
  logic        pageFresh_q;
  logic        lpaRead;
  logic        baseCheck;
  logic        nextCheck;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      shadowPage_q <= anps_pkg::RESET_WORD;
      pageFresh_q  <= 1'b0;
    end else begin
      pageFresh_q <= pageValid;
      if (pageValid) begin
        shadowPage_q <= pageWord;
      end
    end
  end

  // a read one cycle after a page still returns the older word, so skip it
  assign lpaRead   = mgmtRead && (mgmtAddr == anps_pkg::REG_LINK_PARTNER_ABILITY);
  assign baseCheck = lpaRead && !pageFresh_q && (pageFmt_q == anps_pkg::PG_BASE);
  assign nextCheck = lpaRead && !pageFresh_q && (pageFmt_q == anps_pkg::PG_NEXT);

  a_fault_latches: assert property (@(posedge mclk) disable iff (!nrst) // R13
    $past(multiLink) |-> parallelError_q)
    else $error("parallel fault not latched");

  a_fault_holds: assert property (@(posedge mclk) disable iff (!nrst) // R19
    parallelError_q && !readExp |=> parallelError_q)
    else $error("parallel fault dropped without read");

  a_fault_clear: assert property (@(posedge mclk) disable iff (!nrst) // R13
    parallelError_q && readExp && !multiLink |=> !parallelError_q)
    else $error("parallel fault not cleared by read");

  a_fault_out: assert property (@(posedge mclk) disable iff (!nrst) // R13
    1'b1 |=> parallelErrorOut == $past(parallelError_q))
    else $error("fault output does not follow flag");

  a_multi_link: assert property (@(posedge mclk) disable iff (!nrst) // R14
    ($countones(linkValid) > 1) |=> multiLink)
    else $error("multiple links not flagged");

  a_single_link: assert property (@(posedge mclk) disable iff (!nrst) // R14
    ($countones(linkValid) < 2) |=> !multiLink)
    else $error("single link flagged as fault");

  a_page_latch: assert property (@(posedge mclk) disable iff (!nrst) // R17
    pageValid |=> pageArrived_q)
    else $error("page arrival not latched");

  a_page_clear: assert property (@(posedge mclk) disable iff (!nrst) // R17
    pageArrived_q && readExp && !pageValid |=> !pageArrived_q)
    else $error("page arrival not cleared by read");

  a_page_holds: assert property (@(posedge mclk) disable iff (!nrst) // R19
    pageArrived_q && !readExp |=> pageArrived_q)
    else $error("page arrival dropped without read");

  a_own_extra: assert property (@(posedge mclk) disable iff (!nrst) // R16
    mgmtRead && mgmtAddr == anps_pkg::REG_AUTONEG_EXPANSION
      |=> mgmtRdData[anps_pkg::EXP_OWN_EXTRA] && mgmtRdData[15:5] == 11'h000)
    else $error("expansion own bit or reserved wrong");

  a_rsvd_zero: assert property (@(posedge mclk) disable iff (!nrst) // R5
    mgmtRead && mgmtAddr == anps_pkg::REG_LINK_PARTNER_ABILITY
      && pageFmt_q == anps_pkg::PG_BASE |=> mgmtRdData[12:10] == 3'h0)
    else $error("reserved base bits not zero");

  a_format_switch: assert property (@(posedge mclk) disable iff (!nrst) // R20
    nextPageActive |=> pageFmt_q == anps_pkg::PG_NEXT)
    else $error("layout did not switch");

  a_format_back: assert property (@(posedge mclk) disable iff (!nrst) // R20
    !nextPageActive |=> pageFmt_q == anps_pkg::PG_BASE)
    else $error("layout did not return to base");

  a_partner_neg: assert property (@(posedge mclk) disable iff (!nrst) // R18
    partnerNegotiates |=> partnerNeg_q)
    else $error("partner negotiation not shown");

  a_neg_drop: assert property (@(posedge mclk) disable iff (!nrst) // R18
    !partnerNegotiates |=> !partnerNeg_q)
    else $error("partner negotiation shown without cause");

  a_ability_data: assert property (@(posedge mclk) disable iff (!nrst) // R1
    pageValid && !nextPageActive ##1 !pageValid && !nextPageActive ##1
      mgmtRead && mgmtAddr == anps_pkg::REG_LINK_PARTNER_ABILITY
      |=> mgmtRdData[15:13] == $past(pageWord[15:13], 3))
    else $error("base page bits wrong");

  a_extra_cap: assert property (@(posedge mclk) disable iff (!nrst) // R15
    pageValid && pageFmt_q == anps_pkg::PG_BASE
      |=> partnerExtra_q == $past(pageWord[anps_pkg::LPA_MORE_PAGES]))
    else $error("partner next-page support wrong");

  a_extra_kept: assert property (@(posedge mclk) disable iff (!nrst) // R15
    !(pageValid && pageFmt_q == anps_pkg::PG_BASE) |=> $stable(partnerExtra_q))
    else $error("partner next-page support changed outside base page");

  a_base_more: assert property (@(posedge mclk) disable iff (!nrst) // R1
    baseCheck |=> mgmtRdData[anps_pkg::LPA_MORE_PAGES]
      == $past(shadowPage_q[anps_pkg::LPA_MORE_PAGES]))
    else $error("base next-page request bit wrong");

  a_base_ack: assert property (@(posedge mclk) disable iff (!nrst) // R2
    baseCheck |=> mgmtRdData[anps_pkg::LPA_ACKNOWLEDGE]
      == $past(shadowPage_q[anps_pkg::LPA_ACKNOWLEDGE]))
    else $error("base acknowledge bit wrong");

  a_base_fault: assert property (@(posedge mclk) disable iff (!nrst) // R3
    baseCheck |=> mgmtRdData[anps_pkg::LPA_FAULT_FLAG]
      == $past(shadowPage_q[anps_pkg::LPA_FAULT_FLAG]))
    else $error("base fault bit wrong");

  a_base_tech: assert property (@(posedge mclk) disable iff (!nrst) // R4
    baseCheck |=> mgmtRdData[anps_pkg::LPA_T4_CAPABLE:anps_pkg::LPA_SLOW_CAPABLE]
      == $past(shadowPage_q[anps_pkg::LPA_T4_CAPABLE:anps_pkg::LPA_SLOW_CAPABLE]))
    else $error("base technology bits wrong");

  a_base_selector: assert property (@(posedge mclk) disable iff (!nrst) // R6
    baseCheck |=> mgmtRdData[anps_pkg::LPA_SELECTOR_HI:anps_pkg::LPA_SELECTOR_LO]
      == $past(shadowPage_q[anps_pkg::LPA_SELECTOR_HI:anps_pkg::LPA_SELECTOR_LO]))
    else $error("base selector field wrong");

  a_next_more: assert property (@(posedge mclk) disable iff (!nrst) // R7
    nextCheck |=> mgmtRdData[anps_pkg::LPA_MORE_PAGES]
      == $past(shadowPage_q[anps_pkg::LPA_MORE_PAGES]))
    else $error("next page more-pages bit wrong");

  a_next_ack: assert property (@(posedge mclk) disable iff (!nrst) // R8
    nextCheck |=> mgmtRdData[anps_pkg::LPA_ACKNOWLEDGE]
      == $past(shadowPage_q[anps_pkg::LPA_ACKNOWLEDGE]))
    else $error("next page acknowledge bit wrong");

  a_next_message: assert property (@(posedge mclk) disable iff (!nrst) // R9
    nextCheck |=> mgmtRdData[anps_pkg::LPN_MESSAGE_FLAG]
      == $past(shadowPage_q[anps_pkg::LPN_MESSAGE_FLAG]))
    else $error("next page message bit wrong");

  a_next_comply: assert property (@(posedge mclk) disable iff (!nrst) // R10
    nextCheck |=> mgmtRdData[anps_pkg::LPN_COMPLY_FLAG]
      == $past(shadowPage_q[anps_pkg::LPN_COMPLY_FLAG]))
    else $error("next page comply bit wrong");

  a_next_toggle: assert property (@(posedge mclk) disable iff (!nrst) // R11
    nextCheck |=> mgmtRdData[anps_pkg::LPN_ALTERNATE_BIT]
      == $past(shadowPage_q[anps_pkg::LPN_ALTERNATE_BIT]))
    else $error("next page alternating bit wrong");

  a_next_code: assert property (@(posedge mclk) disable iff (!nrst) // R12
    nextCheck |=> mgmtRdData[anps_pkg::LPN_CODE_HI:anps_pkg::LPN_CODE_LO]
      == $past(shadowPage_q[anps_pkg::LPN_CODE_HI:anps_pkg::LPN_CODE_LO]))
    else $error("next page code field wrong");

  a_write_ignored: assert property (@(posedge mclk) disable iff (!nrst) // R21
    mgmtWrite && !mgmtRead |=> $stable(mgmtRdData))
    else $error("write changed read data");

  a_unmapped_zero: assert property (@(posedge mclk) disable iff (!nrst) // R21
    mgmtRead && mgmtAddr != anps_pkg::REG_LINK_PARTNER_ABILITY
      && mgmtAddr != anps_pkg::REG_AUTONEG_EXPANSION |=> mgmtRdData == anps_pkg::RESET_WORD)
    else $error("unmapped read not zero");

  a_valid_pulse: assert property (@(posedge mclk) disable iff (!nrst) // R21
    mgmtRead |=> mgmtRdValid)
    else $error("read not answered");

  a_valid_idle: assert property (@(posedge mclk) disable iff (!nrst) // R21
    !mgmtRead |=> !mgmtRdValid)
    else $error("read valid without read");

endmodule : anps_status_regs

// *** tb/anps_mgmt_model.sv ***
// station management side: plain strobe reads and writes
module anps_mgmt_model (
  input  wire logic        mclk,
  input  wire logic [15:0] mgmtRdData,
  input  wire logic        mgmtRdValid,
  output logic             mgmtRead,
  output logic             mgmtWrite,
  output logic [4:0]       mgmtAddr,
  output logic [15:0]      mgmtWrData
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    mgmtRead   = 1'b0;
    mgmtWrite  = 1'b0;
    mgmtAddr   = 5'h1f;
    mgmtWrData = 16'h0000;
  end

  // idle address and data are inverted so a stale value never looks valid
  task doRead(input logic [4:0] a, output logic [15:0] d, output logic v);
    mgmtAddr <= a;
    mgmtRead <= 1'b1;
    @(posedge mclk);
    mgmtRead <= 1'b0;
    mgmtAddr <= ~a;
    // valid stands for one cycle only: take both just after the answering edge
    #1;
    d = mgmtRdData;
    v = mgmtRdValid;
    @(posedge mclk);
  endtask : doRead

  task doWrite(input logic [4:0] a, input logic [15:0] w);
    mgmtAddr   <= a;
    mgmtWrData <= w;
    mgmtWrite  <= 1'b1;
    @(posedge mclk);
    mgmtWrite  <= 1'b0;
    mgmtAddr   <= ~a;
    mgmtWrData <= ~w;
    @(posedge mclk);
  endtask : doWrite
endmodule : anps_mgmt_model

// *** tb/autoneg_partner_ability_status_tb.sv ***
module autoneg_partner_ability_status_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        mclk;
  logic        nrst;
  logic        pageValid;
  logic [15:0] pageWord;
  logic        nextPageActive;
  logic        partnerNegotiates;
  logic [2:0]  linkValid;
  logic        mgmtRead;
  logic        mgmtWrite;
  logic [4:0]  mgmtAddr;
  logic [15:0] mgmtWrData;
  logic [15:0] mgmtRdData;
  logic        mgmtRdValid;
  logic        parallelErrorOut;
  int          fails;
  int          cmpCount;
  int          cycles;

  anps_status_regs u_anps_status_regs (
    .mclk(mclk), .nrst(nrst), .pageValid(pageValid), .pageWord(pageWord),
    .nextPageActive(nextPageActive), .partnerNegotiates(partnerNegotiates),
    .linkValid(linkValid), .mgmtRead(mgmtRead), .mgmtWrite(mgmtWrite),
    .mgmtAddr(mgmtAddr), .mgmtWrData(mgmtWrData), .mgmtRdData(mgmtRdData),
    .mgmtRdValid(mgmtRdValid), .parallelErrorOut(parallelErrorOut)
  );

  anps_mgmt_model u_anps_mgmt_model (
    .mclk(mclk), .mgmtRdData(mgmtRdData), .mgmtRdValid(mgmtRdValid),
    .mgmtRead(mgmtRead), .mgmtWrite(mgmtWrite), .mgmtAddr(mgmtAddr),
    .mgmtWrData(mgmtWrData)
  );

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task summarize;
    $display("comparisons %0d mismatches %0d", cmpCount, fails);
    if (fails == 0 && cmpCount > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : summarize

  // run is under a hundred cycles; ceiling leaves ample margin
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fails = fails + 1;
      summarize();
    end
  end

  task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    cmpCount = cmpCount + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task rd(input logic [4:0] a, input logic [15:0] exp);
    logic [15:0] d;
    logic        v;
    u_anps_mgmt_model.doRead(a, d, v);
    chk("rdValid", 16'h0001, {15'h0000, v});
    chk("rdData", exp, d);
  endtask : rd

  // word becomes readable two edges after the strobe
  task sendPage(input logic [15:0] w);
    pageWord  <= w;
    pageValid <= 1'b1;
    @(posedge mclk);
    pageValid <= 1'b0;
    pageWord  <= ~w;
    repeat (2) @(posedge mclk);
  endtask : sendPage

  localparam logic [4:0] LPA = anps_pkg::REG_LINK_PARTNER_ABILITY;
  localparam logic [4:0] EXP = anps_pkg::REG_AUTONEG_EXPANSION;
  logic [15:0] nextPages [2] = '{16'h7abc, 16'h8543};

  initial begin
    fails = 0;
    cmpCount = 0;
    cycles = 0;
    nrst = 1'b0;
    pageValid = 1'b0;
    pageWord = 16'h0000;
    nextPageActive = 1'b0;
    partnerNegotiates = 1'b0;
    linkValid = 3'b000;
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    rd(LPA, 16'h0000);
    rd(EXP, 16'h0004);
    partnerNegotiates <= 1'b1;
    sendPage(16'hffff);
    rd(LPA, 16'he3ff);
    rd(EXP, 16'h000f);
    rd(EXP, 16'h000d);
    sendPage(16'h0001);
    u_anps_mgmt_model.doWrite(LPA, 16'hffff);
    u_anps_mgmt_model.doWrite(EXP, 16'hffff);
    rd(LPA, 16'h0001);
    rd(EXP, 16'h0007);
    nextPageActive <= 1'b1;
    @(posedge mclk);
    foreach (nextPages[i]) begin
      sendPage(nextPages[i]);
      rd(LPA, nextPages[i]);
    end
    rd(EXP, 16'h0007);
    nextPageActive <= 1'b0;
    @(posedge mclk);
    rd(LPA, 16'h8143);
    partnerNegotiates <= 1'b0;
    linkValid <= 3'b100;
    repeat (4) @(posedge mclk);
    #1;
    chk("parallelErrorOut", 16'h0000, {15'h0000, parallelErrorOut});
    @(posedge mclk);
    linkValid <= 3'b011;
    @(posedge mclk);
    linkValid <= 3'b000;
    repeat (3) @(posedge mclk);
    #1;
    chk("parallelErrorOut", 16'h0001, {15'h0000, parallelErrorOut});
    @(posedge mclk);
    rd(EXP, 16'h0014);
    rd(EXP, 16'h0004);
    rd(5'h07, 16'h0000);
    // latched flags set, then a reset in mid-run must clear them
    sendPage(16'h8001);
    nrst <= 1'b0;
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    rd(EXP, 16'h0004);
    rd(LPA, 16'h0000);
    summarize();
  end
endmodule : autoneg_partner_ability_status_tb
